// ===== hw/sensorless_bemf_commutator.sv
// sensorless bemf integration commutator with register port and gate drive
`timescale 1ns/1ps
`default_nettype none
module sensorless_bemf_commutator
	import bemf_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic [bemf_pkg::AW-1:0] addr,
	input  wire logic [bemf_pkg::DW-1:0] wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic      [bemf_pkg::DW-1:0] rdata,
	input  wire logic [bemf_pkg::ADC_W-1:0] phase_adc,
	input  wire logic [bemf_pkg::ADC_W-1:0] bus_adc,
	output logic      [2:0]              high_gate,
	output logic      [2:0]              low_gate,
	output logic      [1:0]              float_sel,
	output logic                         sample_strobe
);
	import bemf_pkg::*;

	// ============================================================
	// pwm timebase
	pwm_link_if #(.W(DW)) link ();
	pwm_timebase #(.W(DW)) u_tb (
		.clk   (clk),
		.rst_n (rst_n),
		.link  (link)
	);

	// ============================================================
	// registers
	logic [DW-1:0]    thresh_reg, blank_reg, poles_reg, speed_reg, freq_reg, duty_reg;
	logic             en_reg;
	logic             late_reg;
	logic [DW-1:0]    rdata_reg;
	phase_state_t     state_reg, state_next;
	logic [2:0]       step_reg;
	logic [ACC_W-1:0] acc_reg;
	logic [DW-1:0]    skip_reg;
	logic [DW-1:0]    since_reg;
	logic [DW-1:0]    last_per_reg;
	logic             sign_reg;

	wire wr_ctrl   = wr && (addr == OFS_CTRL);
	wire wr_thresh = wr && (addr == OFS_THRESH)
		&& (wdata >= THRESH_MIN) && (wdata <= THRESH_MAX);
	wire wr_blank  = wr && (addr == OFS_BLANK);
	wire wr_poles  = wr && (addr == OFS_POLES)
		&& (wdata >= POLES_MIN) && (wdata <= POLES_MAX);
	wire wr_speed  = wr && (addr == OFS_SPEED)
		&& (wdata >= SPEED_MIN) && (wdata <= SPEED_MAX);
	wire wr_freq   = wr && (addr == OFS_FREQ)
		&& (wdata >= FREQ_MIN) && (wdata <= FREQ_MAX);
	wire wr_duty   = wr && (addr == OFS_DUTY);
	wire wr_status = wr && (addr == OFS_STATUS);

	// wide divide in logic; the timebase compares period and on_time against the counter on every clock
	wire [31:0] per_full = CLK_HZ / {16'h0000, freq_reg};
	wire [31:0] on_full  = (per_full * {16'h0000, duty_reg}) >> 8;
	assign link.period  = per_full[DW-1:0];
	assign link.on_time = on_full[DW-1:0];

	// ============================================================
	// floating phase sampling
	// adc words settle long before the tick, so a two-stage pass is enough
	logic [ADC_W-1:0] ph_s1, ph_s2, bus_s1, bus_s2;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ph_s1  <= '0;
			ph_s2  <= '0;
			bus_s1 <= '0;
			bus_s2 <= '0;
		end else begin
			ph_s1  <= phase_adc;
			ph_s2  <= ph_s1;
			bus_s1 <= bus_adc;
			bus_s2 <= bus_s1;
		end
	end

	// sign relative to half bus
	wire signed [ADC_W+1:0] diff = $signed({2'b00, ph_s2}) - $signed({3'b000, bus_s2[ADC_W-1:1]});
	wire                    sgn  = diff[ADC_W+1];
	wire [ADC_W:0]          mag  = sgn ? '0 - diff[ADC_W:0] : diff[ADC_W:0];
	wire [ACC_W-1:0]        acc_sum = acc_reg + ACC_W'(mag);
	wire                    tick = link.tick;

	// ============================================================
	// commutation state machine
	// never fewer than three samples skipped, whatever blanking says
	wire [DW-1:0] skip_len = (blank_reg < MIN_SKIP) ? MIN_SKIP : blank_reg;
	wire          skip_done = (skip_reg >= skip_len - DW'(1));
	wire          crossing  = (sgn != sign_reg);
	// threshold is tuned so switching falls at equal bemf on both phases
	wire          reach     = (acc_sum >= ACC_W'(thresh_reg));
	wire          commute   = en_reg && tick && (state_reg == ST_INTEG) && reach;
	wire          late_hit  = en_reg && tick && (state_reg == ST_BLANK) && skip_done
		&& (last_per_reg != '0) && (since_reg >= (last_per_reg >> 1));

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_BLANK: if (tick && skip_done) state_next = ST_WAIT;
			ST_WAIT:  if (tick && crossing) state_next = ST_INTEG;
			ST_INTEG: if (commute) state_next = ST_BLANK;
			default:  state_next = ST_BLANK;
		endcase
		if (!en_reg) state_next = ST_BLANK;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg    <= ST_BLANK;
			step_reg     <= 3'd0;
			acc_reg      <= '0;
			skip_reg     <= '0;
			since_reg    <= '0;
			last_per_reg <= '0;
			sign_reg     <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (!en_reg) begin
				acc_reg   <= '0;
				skip_reg  <= '0;
				since_reg <= '0;
			end else if (tick) begin
				since_reg <= (since_reg == '1) ? since_reg : since_reg + DW'(1);
				case (state_reg)
					ST_BLANK: begin
						skip_reg <= skip_reg + DW'(1); // samples ignored
						sign_reg <= sgn;
					end
					ST_WAIT: begin
						sign_reg <= sgn;
						acc_reg  <= crossing ? ACC_W'(mag) : '0;
					end
					ST_INTEG: begin
						acc_reg <= reach ? '0 : acc_sum;
						if (reach) begin
							step_reg     <= (step_reg == LAST_STEP) ? 3'd0 : step_reg + 3'd1;
							skip_reg     <= '0;
							last_per_reg <= since_reg + DW'(1);
							since_reg    <= '0;
						end
					end
					default: acc_reg <= '0;
				endcase
			end
		end
	end

	// ============================================================
	// gate drive: one top, one bottom, third phase floats
	logic [2:0] hi_sel, lo_sel;
	logic [1:0] fl_sel;
	always_comb begin
		case (step_reg)
			3'd0:    begin hi_sel = 3'b001; lo_sel = 3'b010; fl_sel = 2'd2; end
			3'd1:    begin hi_sel = 3'b001; lo_sel = 3'b100; fl_sel = 2'd1; end
			3'd2:    begin hi_sel = 3'b010; lo_sel = 3'b100; fl_sel = 2'd0; end
			3'd3:    begin hi_sel = 3'b010; lo_sel = 3'b001; fl_sel = 2'd2; end
			3'd4:    begin hi_sel = 3'b100; lo_sel = 3'b001; fl_sel = 2'd1; end
			3'd5:    begin hi_sel = 3'b100; lo_sel = 3'b010; fl_sel = 2'd0; end
			default: begin hi_sel = 3'b000; lo_sel = 3'b000; fl_sel = 2'd0; end
		endcase
	end

	logic [2:0] high_reg, low_reg;
	logic [1:0] float_reg;
	logic       strobe_reg;
	wire        drive = en_reg && link.pwm; // both diagonal switches share it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			high_reg   <= 3'b000;
			low_reg    <= 3'b000;
			float_reg  <= 2'd0;
			strobe_reg <= 1'b0;
		end else begin
			high_reg   <= drive ? hi_sel : 3'b000;
			low_reg    <= drive ? lo_sel : 3'b000;
			float_reg  <= fl_sel;
			strobe_reg <= tick;
		end
	end
	assign high_gate     = high_reg;
	assign low_gate      = low_reg;
	assign float_sel     = float_reg;
	assign sample_strobe = strobe_reg;

	// ============================================================
	// register port
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			en_reg     <= 1'b0;
			thresh_reg <= RST_THRESH;
			blank_reg  <= RST_BLANK;
			poles_reg  <= RST_POLES;
			speed_reg  <= RST_SPEED;
			freq_reg   <= RST_FREQ;
			duty_reg   <= RST_DUTY;
			late_reg   <= 1'b0;
		end else begin
			if (wr_ctrl)   en_reg     <= wdata[CTRL_EN_BIT];
			if (wr_thresh) thresh_reg <= wdata;
			if (wr_blank)  blank_reg  <= wdata;
			if (wr_poles)  poles_reg  <= wdata;
			if (wr_speed)  speed_reg  <= wdata;
			if (wr_freq)   freq_reg   <= wdata;
			if (wr_duty)   duty_reg   <= {8'h00, wdata[7:0]};
			// a new late event wins over a clear in the same cycle
			if (late_hit)
				late_reg <= 1'b1;
			else if (wr_status && wdata[STAT_LATE_BIT])
				late_reg <= 1'b0;
		end
	end

	logic [DW-1:0] rd_mux;
	always_comb begin
		case (addr)
			OFS_CTRL:     rd_mux = {15'h0000, en_reg};
			OFS_THRESH:   rd_mux = thresh_reg;
			OFS_BLANK:    rd_mux = blank_reg;
			OFS_POLES:    rd_mux = poles_reg;
			OFS_SPEED:    rd_mux = speed_reg;
			OFS_FREQ:     rd_mux = freq_reg;
			OFS_DUTY:     rd_mux = duty_reg;
			OFS_STATUS:   rd_mux = {7'h00, late_reg, 2'b00, state_reg, 1'b0, step_reg};
			OFS_INTEGRAL: rd_mux = acc_reg[ACC_W-1:ACC_W-DW];
			default:      rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) rdata_reg <= '0;
		else        rdata_reg <= rd ? rd_mux : 16'h0000;
	end
	assign rdata = rdata_reg;
endmodule : sensorless_bemf_commutator
`default_nettype wire

// ===== pkg/bemf_pkg.sv
// constants, register map and state types of the sensorless commutator
//
// Notes on behaviour
// - two phases driven, third left floating
// - integration starts at floating phase zero crossing
// - integral reaching threshold advances commutation step
// - first three samples after commutation ignored
// - blanking length configurable in pwm cycles
// - diagonal top and bottom share one pwm
// - freewheeling must end before half commutation period
// - threshold places commutation at equal bemf amplitude
// - pole pairs, speed, frequency limited to ranges
// - threshold accepts 100 to 65000
`default_nettype none
package bemf_pkg;
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int          AW     = 4;
	localparam int          DW     = 16;
	localparam int          ADC_W  = 12;
	localparam int          ACC_W  = 20;

	// register offsets
	localparam logic [AW-1:0] OFS_CTRL     = 4'h0;
	localparam logic [AW-1:0] OFS_THRESH   = 4'h1;
	localparam logic [AW-1:0] OFS_BLANK    = 4'h2;
	localparam logic [AW-1:0] OFS_POLES    = 4'h3;
	localparam logic [AW-1:0] OFS_SPEED    = 4'h4;
	localparam logic [AW-1:0] OFS_FREQ     = 4'h5;
	localparam logic [AW-1:0] OFS_DUTY     = 4'h6;
	localparam logic [AW-1:0] OFS_STATUS   = 4'h7;
	localparam logic [AW-1:0] OFS_INTEGRAL = 4'h8;

	// field positions
	localparam int CTRL_EN_BIT     = 0;
	localparam int STAT_LATE_BIT   = 8;

	// reset values
	localparam logic [DW-1:0] RST_THRESH = 16'h03e8;
	localparam logic [DW-1:0] RST_BLANK  = 16'h0003;
	localparam logic [DW-1:0] RST_POLES  = 16'h0001;
	localparam logic [DW-1:0] RST_SPEED  = 16'h0bb8;
	localparam logic [DW-1:0] RST_FREQ   = 16'h4e20;
	localparam logic [DW-1:0] RST_DUTY   = 16'h0080;

	// accepted ranges
	localparam logic [DW-1:0] THRESH_MIN = 16'd100;
	localparam logic [DW-1:0] THRESH_MAX = 16'd65000;
	localparam logic [DW-1:0] POLES_MIN  = 16'd1;
	localparam logic [DW-1:0] POLES_MAX  = 16'd48;
	localparam logic [DW-1:0] SPEED_MIN  = 16'd500;
	localparam logic [DW-1:0] SPEED_MAX  = 16'd30000;
	localparam logic [DW-1:0] FREQ_MIN   = 16'd5000;
	localparam logic [DW-1:0] FREQ_MAX   = 16'd40000;

	// fewest samples ignored after each commutation, whatever the blanking setting
	localparam logic [DW-1:0] MIN_SKIP   = 16'd3;
	localparam logic [2:0]    LAST_STEP  = 3'd5;

	typedef enum logic [1:0] {
		ST_BLANK = 2'b00,
		ST_WAIT  = 2'b01,
		ST_INTEG = 2'b10
	} phase_state_t;
endpackage : bemf_pkg
`default_nettype wire

// ===== pkg/pwm_link_if.sv
// pwm settings toward the timebase and its pwm level and sample tick back
`timescale 1ns/1ps
`default_nettype none
interface pwm_link_if #(parameter int W = 16);
	logic [W-1:0] period;
	logic [W-1:0] on_time;
	logic         pwm;
	logic         tick;
	modport gen (input period, input on_time, output pwm, output tick);
	modport ctl (output period, output on_time, input pwm, input tick);
endinterface : pwm_link_if
`default_nettype wire

// ===== hw/pwm_timebase.sv
// pwm counter: one pwm level and one sample tick per period
`timescale 1ns/1ps
`default_nettype none
module pwm_timebase #(
	parameter int W = 16
) (
	input  wire logic clk,
	input  wire logic rst_n,
	pwm_link_if.gen   link
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic         pwm_reg;
	logic         tick_reg;
	wire          wrap;

	generate
		if (W < 13) begin : g_chk
			$error("pwm_timebase: W too small for the slowest pwm period");
		end
	endgenerate

	assign wrap     = (cnt_reg >= link.period - W'(1));
	assign cnt_next = wrap ? '0 : cnt_reg + W'(1);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg  <= '0;
			pwm_reg  <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			pwm_reg  <= (cnt_next < link.on_time);
			tick_reg <= wrap; // one sample per pwm period
		end
	end

	assign link.pwm  = pwm_reg;
	assign link.tick = tick_reg;
endmodule : pwm_timebase
`default_nettype wire

// ===== dv/sensorless_bemf_commutator_sva.sv
// port assertions for the sensorless commutator
`timescale 1ns/1ps
`default_nettype none
module commutator_sva
	import bemf_pkg::*;
(
	input wire logic                    clk,
	input wire logic                    rst_n,
	input wire logic [bemf_pkg::AW-1:0] addr,
	input wire logic [bemf_pkg::DW-1:0] wdata,
	input wire logic                    wr,
	input wire logic                    rd,
	input wire logic [bemf_pkg::DW-1:0] rdata,
	input wire logic [2:0]              high_gate,
	input wire logic [2:0]              low_gate,
	input wire logic [1:0]              float_sel,
	input wire logic                    sample_strobe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [3:0]    strobes_reg;
	logic          moved_reg;
	logic [DW-1:0] thresh_reg;
	// ==========
	// helpers: samples since last commutation, shadow threshold
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			strobes_reg <= 4'h0;
			moved_reg   <= 1'b0;
			thresh_reg  <= RST_THRESH;
		end else begin
			if ($changed(float_sel))
				moved_reg <= 1'b1;
			if ($changed(float_sel))
				strobes_reg <= 4'h0;
			else if (sample_strobe && strobes_reg != 4'hf)
				strobes_reg <= strobes_reg + 4'h1;
			if (wr && addr == OFS_THRESH && wdata >= THRESH_MIN && wdata <= THRESH_MAX)
				thresh_reg <= wdata;
		end
	end
	// ==========
	// assertions
	property p_float_free; ((high_gate | low_gate) & (3'b001 << float_sel)) == 3'b000; endproperty
	a_float_free: assert property (p_float_free) else $error("floating phase driven");
	property p_two_phases; $onehot0(high_gate) && $onehot0(low_gate) && (high_gate & low_gate) == 3'b000; endproperty
	a_two_phases: assert property (p_two_phases) else $error("more than two phases driven");
	property p_same_pwm; (high_gate != 3'b000) == (low_gate != 3'b000); endproperty
	a_same_pwm: assert property (p_same_pwm) else $error("top and bottom pwm differ");
	property p_order; $changed(float_sel) |-> float_sel == (($past(float_sel) == 2'd0) ? 2'd2 : $past(float_sel) - 2'd1);
	endproperty
	a_order: assert property (p_order) else $error("commutation step out of order");
	property p_blank; $changed(float_sel) && moved_reg |-> strobes_reg >= 4'd4; endproperty
	a_blank: assert property (p_blank) else $error("commutation inside blanking");
	property p_sample; sample_strobe |=> (!sample_strobe) [*8]; endproperty
	a_sample: assert property (p_sample) else $error("samples too close");
	property p_thresh; rd && addr == OFS_THRESH |=> rdata == thresh_reg; endproperty
	a_thresh: assert property (p_thresh) else $error("threshold range not kept");
	property p_poles; rd && addr == OFS_POLES |=> rdata >= POLES_MIN && rdata <= POLES_MAX; endproperty
	a_poles: assert property (p_poles) else $error("pole pairs out of range");
	property p_freq; rd && addr == OFS_FREQ |=> rdata >= FREQ_MIN && rdata <= FREQ_MAX; endproperty
	a_freq: assert property (p_freq) else $error("frequency out of range");
endmodule : commutator_sva
bind sensorless_bemf_commutator commutator_sva u_sva (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .high_gate(high_gate), .low_gate(low_gate), .float_sel(float_sel),
	.sample_strobe(sample_strobe));
`default_nettype wire

// ===== dv/motor_stage_model.sv
// inverter and motor: floating phase ramps through zero after each commutation
`timescale 1ns/1ps
`default_nettype none
module motor_stage_model
	import bemf_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [2:0]         high_gate,
	input  wire logic [1:0]         float_sel,
	input  wire logic               sample_strobe,
	output logic      [ADC_W-1:0]   phase_adc,
	output logic      [ADC_W-1:0]   bus_adc
);
	logic [3:0] n_reg;
	logic [1:0] fl_reg;
	logic       run_reg;
	// sample n: v = 40n - 180, so samples 1..4 are still recirculation side and 5 crosses
	function automatic logic [ADC_W-1:0] level(input logic [3:0] n);
		return 12'h400 + 12'(n) * 12'h028 - 12'h0b4;
	endfunction : level
	assign bus_adc = 12'h800;
	// ==========
	// ramp restarts on commutation and when drive first starts
	always_ff @(posedge clk) begin
		fl_reg <= float_sel;
		if (!rst_n) begin
			run_reg   <= 1'b0;
			n_reg     <= 4'h1;
			phase_adc <= level(4'h1);
		end else if (float_sel != fl_reg || (!run_reg && high_gate != 3'b000)) begin
			run_reg   <= 1'b1;
			n_reg     <= 4'h1;
			phase_adc <= level(4'h1);
		end else if (sample_strobe && n_reg != 4'hf) begin
			n_reg     <= n_reg + 4'h1;
			phase_adc <= level(n_reg + 4'h1);
		end
	end
endmodule : motor_stage_model
`default_nettype wire

// ===== dv/tb_sensorless_bemf_commutator.sv
// testbench for the sensorless commutator
`timescale 1ns/1ps
`default_nettype none
module tb_sensorless_bemf_commutator;
	import bemf_pkg::*;
	logic             clk, rst_n, wr, rd, sample_strobe;
	logic [AW-1:0]    addr;
	logic [DW-1:0]    wdata, rdata, v;
	logic [ADC_W-1:0] phase_adc, bus_adc;
	logic [2:0]       high_gate, low_gate;
	logic [1:0]       float_sel, f;
	int               fails, checks, cycles, strobes, t;
	// ==========
	// rows: write flag, offset, data, value read back
	logic [36:0] rows [22] = '{{1'b0,4'h0,16'h0,16'h0000}, {1'b0,4'h1,16'h0,16'h03e8}, {1'b0,4'h2,16'h0,16'h0003},
		{1'b0,4'h3,16'h0,16'h0001}, {1'b0,4'h4,16'h0,16'h0bb8}, {1'b0,4'h5,16'h0,16'h4e20},
		{1'b0,4'h6,16'h0,16'h0080}, {1'b0,4'hf,16'h0,16'h0000}, {1'b1,4'h1,16'h0063,16'h03e8},
		{1'b1,4'h1,16'hfde9,16'h03e8}, {1'b1,4'h1,16'hfde8,16'hfde8}, {1'b1,4'h1,16'h0064,16'h0064},
		{1'b1,4'h3,16'h0000,16'h0001}, {1'b1,4'h3,16'h0031,16'h0001}, {1'b1,4'h3,16'h0030,16'h0030},
		{1'b1,4'h4,16'h01f3,16'h0bb8}, {1'b1,4'h4,16'h7531,16'h0bb8}, {1'b1,4'h4,16'h7530,16'h7530},
		{1'b1,4'h4,16'h01f4,16'h01f4}, {1'b1,4'h5,16'h1387,16'h4e20}, {1'b1,4'h5,16'h9c41,16'h4e20},
		{1'b1,4'h5,16'h9c40,16'h9c40}};
	// float index, top gates, bottom gates for steps 0..5
	logic [7:0] steps [6] = '{8'h8a, 8'h4c, 8'h14, 8'h91, 8'h61, 8'h22};
	sensorless_bemf_commutator dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .phase_adc(phase_adc), .bus_adc(bus_adc), .high_gate(high_gate), .low_gate(low_gate),
		.float_sel(float_sel), .sample_strobe(sample_strobe));
	motor_stage_model partner (.clk(clk), .rst_n(rst_n), .high_gate(high_gate), .float_sel(float_sel),
		.sample_strobe(sample_strobe), .phase_adc(phase_adc), .bus_adc(bus_adc));
	// ==========
	// tasks
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr
	// read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
		@(posedge clk);
	endtask : reg_rd
	task automatic end_sim;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim
	// ==========
	// clock and hang limit
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			fails++;
			end_sim();
		end
	end
	// ==========
	// main sequence
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 22; i++) begin
			if (rows[i][36]) reg_wr(rows[i][35:32], rows[i][31:16]);
			reg_rd(rows[i][35:32]);
			check("register", v, rows[i][15:0]);
		end
		// threshold 100 and 40 kHz are left in place, so each step needs seven samples
		reg_wr(OFS_CTRL, 16'h0001);
		for (int k = 0; k < 7; k++) begin
			t = 0;
			while (high_gate === 3'b000 && t < 4000) begin
				@(negedge clk);
				t++;
			end
			check("high_gate", {13'h0, high_gate}, {13'h0, steps[k % 6][5:3]});
			check("low_gate", {13'h0, low_gate}, {13'h0, steps[k % 6][2:0]});
			check("float_sel", {14'h0, float_sel}, {14'h0, steps[k % 6][7:6]});
			f = float_sel;
			strobes = 0;
			t = 0;
			while (float_sel === f && t < 8000) begin
				@(negedge clk);
				t++;
				if (sample_strobe === 1'b1) strobes++;
			end
			if (k > 0) check("samples per step", 16'(strobes), 16'h0007);
		end
		// recirculation of three samples stays under half of a seven-sample step
		@(posedge clk);
		reg_rd(OFS_STATUS);
		check("late flag blank 3", {15'h0000, v[STAT_LATE_BIT]}, 16'h0000);
		// four ignored samples reach half the step: late must be flagged
		reg_wr(OFS_BLANK, 16'h0004);
		@(negedge clk);
		f = float_sel;
		t = 0;
		while (float_sel === f && t < 8000) begin
			@(negedge clk);
			t++;
		end
		@(posedge clk);
		reg_rd(OFS_STATUS);
		check("late flag blank 4", {15'h0000, v[STAT_LATE_BIT]}, 16'h0001);
		reg_wr(OFS_STATUS, 16'h0100);
		reg_rd(OFS_STATUS);
		check("late flag cleared", {15'h0000, v[STAT_LATE_BIT]}, 16'h0000);
		@(posedge clk);
		reg_wr(OFS_CTRL, 16'h0000);
		reg_rd(OFS_STATUS);
		check("state after disable", {14'h0, v[5:4]}, 16'h0000);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		reg_rd(OFS_THRESH);
		check("threshold after reset", v, RST_THRESH);
		end_sim();
	end
endmodule : tb_sensorless_bemf_commutator
`default_nettype wire
